/* assl_pkg.sv */
// package: constants, encodings and types of the axis status low bits block
// How it works
// RQ1 - state field sits at status bits five, four
// RQ2 - geared move codes ratio rest, rise, hold, fall
// RQ3 - speed control codes target speed the same way
// RQ4 - open loop codes the drive ramp likewise
// RQ5 - sine move: done, accelerating, decelerating, no hold
// RQ6 - continuous sine: first or second phase half
// RQ7 - spline move keeps state field at zero
// RQ8 - closed-loop halt: decelerating, then zero
// RQ9 - field zero at move end, load, reset
// RQ10 - bit three set whenever axis is open loop
// RQ11 - only closed-loop commands clear open loop bit
// RQ12 - disable or hard stop nulls drive, soft ramps
// RQ13 - open loop command ramps drive at given rates
// RQ14 - bit two set by halt or stop errors
// RQ15 - halt cleared only by error clearing commands
// RQ16 - halted with field zero freezes the integrator
// RQ17 - stopped bit with 50/130 speed hysteresis, unlatched
// RQ18 - in position needs window and closed-loop stop
// RQ19 - closed-loop stopped states listed, gearing excluded
// RQ20 - in position unlatched, drops on leaving window
// RQ21 - all bits re-evaluated once per loop update
package assl_pkg;
  // clock and ramp timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RAMP_STEP_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * RAMP_STEP_MS;
  localparam logic [15:0] SOFT_RAMP_MV = 16'h0064;
  // speed thresholds of the stopped bit, position units per second
  localparam logic [31:0] STOP_BELOW = 32'h0000_0032;
  localparam logic [31:0] RUN_ABOVE = 32'h0000_0082;
  // register byte offsets
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_COMMAND = 8'h04;
  localparam logic [7:0] ADR_CMD_VALUE = 8'h08;
  localparam logic [7:0] ADR_ACCEL = 8'h0C;
  localparam logic [7:0] ADR_DECEL = 8'h10;
  localparam logic [7:0] ADR_NULL_DRIVE = 8'h14;
  localparam logic [7:0] ADR_INPOS_WIN = 8'h18;
  localparam logic [7:0] ADR_DRIVE = 8'h1C;
  // status bit positions
  localparam int unsigned ST_INPOS = 0;
  localparam int unsigned ST_STOPPED = 1;
  localparam int unsigned ST_HALT = 2;
  localparam int unsigned ST_OPEN = 3;
  localparam int unsigned ST_FIELD_LO = 4;
  // command register layout
  localparam int unsigned GO_GEAR_BIT = 8;
  localparam int unsigned GO_ROT_BIT = 9;
  localparam logic [7:0] CMD_PARAM_LOAD = 8'h01;
  localparam logic [7:0] CMD_POS_RESET = 8'h02;
  localparam logic [7:0] CMD_GO = 8'h03;
  localparam logic [7:0] CMD_REL_MOVE = 8'h04;
  localparam logic [7:0] CMD_SPLINE = 8'h05;
  localparam logic [7:0] CMD_SINE = 8'h06;
  localparam logic [7:0] CMD_OPEN_LOOP = 8'h07;
  localparam logic [7:0] CMD_DISABLE = 8'h08;
  localparam logic [7:0] CMD_HALT = 8'h09;
  localparam logic [7:0] CMD_SINE_CONT = 8'h30;
  localparam logic [3:0] CMD_AXIS_REL_HI = 4'hC;
  // reset values
  localparam logic [31:0] RST_INPOS_WIN = 32'h0000_0010;
  // state field codes
  localparam logic [1:0] FLD_REST = 2'h0;
  localparam logic [1:0] FLD_RISE = 2'h1;
  localparam logic [1:0] FLD_HOLD = 2'h2;
  localparam logic [1:0] FLD_FALL = 2'h3;
  // move type, one-hot
  typedef enum logic [8:0] {
    MV_IDLE = 9'h001,
    MV_P2P = 9'h002,
    MV_GEAR = 9'h004,
    MV_SPEED = 9'h008,
    MV_OPEN = 9'h010,
    MV_SINE = 9'h020,
    MV_SINEC = 9'h040,
    MV_SPLINE = 9'h080,
    MV_HALT = 9'h100
  } assl_move_e;
endpackage : assl_pkg

/* assl_axis_status.sv */
// module: low status bits, drive ramp and integrator freeze of one axis
`timescale 1ns/1ps
module assl_axis_status #(
  parameter int unsigned MS_CYCLES = assl_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  // control loop samples
  input wire logic loop_tick,
  input wire logic [31:0] actual_speed,
  input wire logic [31:0] actual_pos,
  input wire logic [31:0] command_pos,
  // target generator progress
  input wire logic tg_busy,
  input wire logic tg_rising,
  input wire logic tg_falling,
  input wire logic tg_req_nonzero,
  input wire logic tg_upper_half,
  // internal stop events
  input wire logic hard_stop,
  input wire logic soft_stop,
  input wire logic soft_stop_xdcr,
  // results
  output logic [5:0] status_bits,
  output logic [15:0] drive_mv,
  output logic integ_freeze,
  output logic tg_start,
  output logic [8:0] tg_move
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // every flip-flop of the block
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] cmd_value;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] null_drv;
    logic [31:0] window;
    logic [15:0] drive;
    logic [15:0] ramp_tgt;
    logic [15:0] ramp_up;
    logic [15:0] ramp_dn;
    logic [31:0] ms_cnt;
    assl_pkg::assl_move_e move;
    logic open_loop;
    logic halt;
    logic start;
    logic freeze;
    logic [5:0] status;
  } assl_state_s;

  assl_state_s r_reg; // registered state
  assl_state_s r_next; // next state

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // magnitude of a signed word
  function automatic logic [31:0] assl_abs(input logic [31:0] v);
    assl_abs = v[31] ? 32'(-v) : v;
  endfunction : assl_abs

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] assl_wr16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
    assl_wr16 = old;
    if (sel[0]) begin
      assl_wr16[7:0] = d[7:0];
    end
    if (sel[1]) begin
      assl_wr16[15:8] = d[15:8];
    end
  endfunction : assl_wr16

  // one ramp step of the drive toward its target, signed millivolts
  function automatic logic [15:0] assl_step(input logic [15:0] cur, input logic [15:0] tgt,
                                            input logic [15:0] up, input logic [15:0] dn);
    logic signed [17:0] c;
    logic signed [17:0] t;
    logic signed [17:0] s;
    c = 18'(signed'(cur));
    t = 18'(signed'(tgt));
    s = c;
    if (c < t) begin
      s = c + 18'({2'h0, up});
      if (s > t) begin
        s = t;
      end
    end else if (c > t) begin
      s = c - 18'({2'h0, dn});
      if (s < t) begin
        s = t;
      end
    end
    assl_step = s[15:0];
  endfunction : assl_step

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  // bus decode, command handling, stop events, ramp and status snapshot
  always_comb begin
    logic req;
    logic cmd_wr;
    logic [7:0] code;
    logic [15:0] ol_tgt;
    logic [31:0] off_now;
    logic [31:0] off_tgt;
    logic [1:0] fld;
    logic stopped;
    logic cl_stop;
    req = 1'b0;
    cmd_wr = 1'b0;
    code = 8'h00;
    ol_tgt = 16'h0000;
    off_now = 32'h0000_0000;
    off_tgt = 32'h0000_0000;
    fld = assl_pkg::FLD_REST;
    stopped = 1'b0;
    cl_stop = 1'b0;
    r_next = r_reg;
    r_next.start = 1'b0;
    // classic single cycle: answer one edge after the request
    req = wb_cyc_i && wb_stb_i && !r_reg.ack;
    r_next.ack = req;
    if (req && !wb_we_i) begin
      // read data, unmapped words read as zero
      case (wb_adr_i)
        assl_pkg::ADR_STATUS: r_next.rdata = {26'h000_0000, r_reg.status};
        assl_pkg::ADR_CMD_VALUE: r_next.rdata = {16'h0000, r_reg.cmd_value};
        assl_pkg::ADR_ACCEL: r_next.rdata = {16'h0000, r_reg.accel};
        assl_pkg::ADR_DECEL: r_next.rdata = {16'h0000, r_reg.decel};
        assl_pkg::ADR_NULL_DRIVE: r_next.rdata = {16'h0000, r_reg.null_drv};
        assl_pkg::ADR_INPOS_WIN: r_next.rdata = r_reg.window;
        assl_pkg::ADR_DRIVE: r_next.rdata = {16'h0000, r_reg.drive};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (req && wb_we_i) begin
      // writes, read-only and unmapped words ignore them
      case (wb_adr_i)
        assl_pkg::ADR_COMMAND: cmd_wr = wb_sel_i[0];
        assl_pkg::ADR_CMD_VALUE: r_next.cmd_value = assl_wr16(r_reg.cmd_value, wb_dat_i, wb_sel_i);
        assl_pkg::ADR_ACCEL: r_next.accel = assl_wr16(r_reg.accel, wb_dat_i, wb_sel_i);
        assl_pkg::ADR_DECEL: r_next.decel = assl_wr16(r_reg.decel, wb_dat_i, wb_sel_i);
        assl_pkg::ADR_NULL_DRIVE: r_next.null_drv = assl_wr16(r_reg.null_drv, wb_dat_i, wb_sel_i);
        assl_pkg::ADR_INPOS_WIN: begin
          r_next.window[15:0] = assl_wr16(r_reg.window[15:0], wb_dat_i, wb_sel_i);
          r_next.window[31:16] = assl_wr16(r_reg.window[31:16], {16'h0000, wb_dat_i[31:16]},
                                           {2'h0, wb_sel_i[3:2]});
        end
        default: cmd_wr = 1'b0;
      endcase
    end
    code = wb_dat_i[7:0];
    // open-loop target is the command value plus null drive
    ol_tgt = r_reg.cmd_value + r_reg.null_drv;
    if (cmd_wr) begin
      // command execution
      if (code == assl_pkg::CMD_PARAM_LOAD || code == assl_pkg::CMD_POS_RESET) begin
        r_next.open_loop = 1'b0; // [RQ11]
        r_next.halt = 1'b0; // [RQ15]
        r_next.move = assl_pkg::MV_IDLE; // [RQ9]
      end else if (code == assl_pkg::CMD_GO || code == assl_pkg::CMD_REL_MOVE ||
                   code[7:4] == assl_pkg::CMD_AXIS_REL_HI || code == assl_pkg::CMD_SPLINE ||
                   code == assl_pkg::CMD_SINE) begin
        r_next.open_loop = 1'b0; // [RQ11]
        r_next.halt = 1'b0; // [RQ15]
        r_next.start = 1'b1;
        if (code == assl_pkg::CMD_SPLINE) begin
          r_next.move = assl_pkg::MV_SPLINE;
        end else if (code == assl_pkg::CMD_SINE) begin
          r_next.move = assl_pkg::MV_SINE;
        end else if (code == assl_pkg::CMD_GO && wb_sel_i[1] && wb_dat_i[assl_pkg::GO_GEAR_BIT]) begin
          r_next.move = assl_pkg::MV_GEAR;
        end else if (code == assl_pkg::CMD_GO && wb_sel_i[1] && wb_dat_i[assl_pkg::GO_ROT_BIT]) begin
          r_next.move = assl_pkg::MV_SPEED;
        end else begin
          r_next.move = assl_pkg::MV_P2P;
        end
      end else if (code == assl_pkg::CMD_SINE_CONT) begin
        // continuous sine runs only from closed loop
        if (!r_reg.open_loop) begin
          r_next.move = assl_pkg::MV_SINEC;
          r_next.start = 1'b1;
        end
      end else if (code == assl_pkg::CMD_OPEN_LOOP) begin
        r_next.open_loop = 1'b1; // [RQ10]
        r_next.move = assl_pkg::MV_OPEN;
        r_next.ramp_tgt = ol_tgt; // [RQ13]
        r_next.ramp_up = r_reg.accel; // [RQ13]
        r_next.ramp_dn = r_reg.decel; // [RQ13]
      end else if (code == assl_pkg::CMD_DISABLE) begin
        r_next.open_loop = 1'b1; // [RQ10]
        r_next.move = assl_pkg::MV_OPEN;
        r_next.drive = r_reg.null_drv; // [RQ12]
        r_next.ramp_tgt = r_reg.null_drv; // [RQ12]
      end else if (code == assl_pkg::CMD_HALT) begin
        r_next.halt = 1'b1; // [RQ14]
        if (!r_reg.open_loop) begin
          r_next.move = assl_pkg::MV_HALT; // [RQ8]
          r_next.start = 1'b1;
        end
      end
    end
    // stop events come after commands so that a set wins over a clear
    if (hard_stop) begin
      r_next.halt = 1'b1; // [RQ14]
      r_next.open_loop = 1'b1; // [RQ10]
      r_next.move = assl_pkg::MV_OPEN;
      r_next.drive = r_reg.null_drv; // [RQ12]
      r_next.ramp_tgt = r_reg.null_drv; // [RQ12]
      r_next.start = 1'b0;
    end else if (soft_stop) begin
      r_next.halt = 1'b1; // [RQ14]
      if (soft_stop_xdcr || r_next.open_loop) begin
        // transducer fault or already open loop: control cannot go on, ramp out
        r_next.open_loop = 1'b1; // [RQ10]
        r_next.move = assl_pkg::MV_OPEN;
        r_next.ramp_tgt = r_reg.null_drv; // [RQ12]
        r_next.ramp_up = assl_pkg::SOFT_RAMP_MV; // [RQ12]
        r_next.ramp_dn = assl_pkg::SOFT_RAMP_MV; // [RQ12]
        r_next.start = 1'b0;
      end else begin
        // closed-loop halt, generator decelerates to zero
        r_next.move = assl_pkg::MV_HALT; // [RQ8]
        r_next.start = 1'b1;
      end
    end
    // millisecond pacing of the drive ramp
    if (r_reg.ms_cnt >= MS_CYCLES - 1) begin
      r_next.ms_cnt = 32'h0000_0000;
      if (r_reg.open_loop && !hard_stop && !(cmd_wr && code == assl_pkg::CMD_DISABLE)) begin
        r_next.drive = assl_step(r_next.drive, r_next.ramp_tgt, r_next.ramp_up, r_next.ramp_dn); // [RQ13]
      end
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + 32'h0000_0001;
    end
    // state field encoding per move type
    off_now = assl_abs(32'(signed'(r_next.drive - r_next.null_drv)));
    off_tgt = assl_abs(32'(signed'(r_next.ramp_tgt - r_next.null_drv)));
    case (r_next.move)
      assl_pkg::MV_GEAR, assl_pkg::MV_SPEED: begin
        // ratio or speed: rising, falling, or at request
        if (tg_rising) begin
          fld = assl_pkg::FLD_RISE; // [RQ2] [RQ3]
        end else if (tg_falling) begin
          fld = assl_pkg::FLD_FALL; // [RQ2] [RQ3]
        end else begin
          fld = tg_req_nonzero ? assl_pkg::FLD_HOLD : assl_pkg::FLD_REST; // [RQ2] [RQ3]
        end
      end
      assl_pkg::MV_OPEN: begin
        // drive moving away from or toward null
        if (r_next.drive == r_next.ramp_tgt) begin
          fld = (off_tgt != 32'h0000_0000) ? assl_pkg::FLD_HOLD : assl_pkg::FLD_REST; // [RQ4]
        end else begin
          fld = (off_tgt > off_now) ? assl_pkg::FLD_RISE : assl_pkg::FLD_FALL; // [RQ4]
        end
      end
      assl_pkg::MV_SINE: begin
        // accelerating, decelerating or done, never hold
        if (tg_busy) begin
          fld = tg_falling ? assl_pkg::FLD_FALL : assl_pkg::FLD_RISE; // [RQ5]
        end
      end
      assl_pkg::MV_SINEC: begin
        // phase half of the continuous sine
        if (tg_busy) begin
          fld = tg_upper_half ? assl_pkg::FLD_FALL : assl_pkg::FLD_RISE; // [RQ6]
        end
      end
      assl_pkg::MV_P2P: begin
        // stage of a point-to-point move
        if (tg_busy) begin
          fld = tg_rising ? assl_pkg::FLD_RISE : (tg_falling ? assl_pkg::FLD_FALL : assl_pkg::FLD_HOLD);
        end
      end
      assl_pkg::MV_HALT: begin
        // decelerating until target speed is zero
        fld = tg_busy ? assl_pkg::FLD_FALL : assl_pkg::FLD_REST; // [RQ8]
      end
      assl_pkg::MV_SPLINE: fld = assl_pkg::FLD_REST; // [RQ7]
      assl_pkg::MV_IDLE: fld = assl_pkg::FLD_REST; // [RQ9]
      default: fld = assl_pkg::FLD_REST;
    endcase
    // stopped bit follows speed with hysteresis
    stopped = r_reg.status[assl_pkg::ST_STOPPED];
    if (assl_abs(actual_speed) < assl_pkg::STOP_BELOW) begin
      stopped = 1'b1; // [RQ17]
    end else if (assl_abs(actual_speed) > assl_pkg::RUN_ABOVE) begin
      stopped = 1'b0; // [RQ17]
    end
    // closed-loop stopped excludes gearing, open loop and a spline still running
    cl_stop = !r_next.open_loop && fld == assl_pkg::FLD_REST && r_next.move != assl_pkg::MV_GEAR &&
              !(r_next.move == assl_pkg::MV_SPLINE && tg_busy); // [RQ19] [RQ20]
    // one coherent snapshot per loop update
    if (loop_tick) begin
      r_next.status[5:4] = fld; // [RQ1] [RQ21]
      r_next.status[assl_pkg::ST_OPEN] = r_next.open_loop; // [RQ10]
      r_next.status[assl_pkg::ST_HALT] = r_next.halt; // [RQ14]
      r_next.status[assl_pkg::ST_STOPPED] = stopped; // [RQ17]
      r_next.status[assl_pkg::ST_INPOS] = cl_stop &&
        (assl_abs(32'(actual_pos - command_pos)) < r_reg.window); // [RQ18] [RQ20]
      r_next.freeze = r_next.halt && fld == assl_pkg::FLD_REST; // [RQ16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // state register with synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.window <= assl_pkg::RST_INPOS_WIN;
      r_reg.move <= assl_pkg::MV_OPEN;
      r_reg.open_loop <= 1'b1;
      r_reg.status <= 6'h0A;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs
  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rdata;
  assign status_bits = r_reg.status;
  assign drive_mv = r_reg.drive;
  assign integ_freeze = r_reg.freeze;
  assign tg_start = r_reg.start;
  assign tg_move = r_reg.move;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking assl_cb @(posedge clk); endclocking
  default disable iff (reset);

  // quiet cycle: no bus write request to any address and no stop event
  logic quiet;
  assign quiet = !(wb_cyc_i && wb_stb_i && wb_we_i && !r_reg.ack) && !hard_stop && !soft_stop;

  // named steps
  sequence s_hard;
    hard_stop;
  endsequence
  sequence s_soft_xdcr;
    soft_stop && soft_stop_xdcr && !hard_stop;
  endsequence
  sequence s_spline_tick;
    loop_tick && quiet && r_reg.move == assl_pkg::MV_SPLINE;
  endsequence

  AST_FIELD_ONLY_ON_TICK: assert property (!loop_tick |=> $stable(status_bits)) // [RQ21]
    else $error("status changed without a loop update");
  AST_SPLINE_ZERO: assert property (s_spline_tick |=> status_bits[5:4] == 2'h0) // [RQ7]
    else $error("spline move shows a nonzero state field");
  AST_SINE_NO_HOLD: assert property (loop_tick && quiet && r_reg.move == assl_pkg::MV_SINE
    |=> status_bits[5:4] != 2'h2) // [RQ5]
    else $error("sine move shows hold code");
  AST_HARD_NULL: assert property (s_hard |=> drive_mv == r_reg.null_drv && r_reg.open_loop) // [RQ12]
    else $error("hard stop did not null the drive");
  AST_HALT_SET: assert property (hard_stop || soft_stop |=> r_reg.halt) // [RQ14]
    else $error("stop event did not set halt");
  AST_SOFT_RAMP: assert property (s_soft_xdcr |=> r_reg.ramp_tgt == r_reg.null_drv
    && r_reg.ramp_dn == assl_pkg::SOFT_RAMP_MV) // [RQ12]
    else $error("soft stop ramp not set to null at its rate");
  AST_OL_CLEAR: assert property ($fell(r_reg.open_loop) |-> $past(wb_we_i && wb_stb_i)
    && $past(wb_adr_i) == assl_pkg::ADR_COMMAND) // [RQ11]
    else $error("open loop cleared without a command");
  AST_HALT_CLEAR: assert property ($fell(r_reg.halt) |-> $past(!hard_stop && !soft_stop)
    && !r_reg.open_loop) // [RQ15]
    else $error("halt cleared by something other than a closed-loop command");
  AST_OL_TICK: assert property (loop_tick && quiet ##1 1 |-> status_bits[3] == r_reg.open_loop) // [RQ10]
    else $error("open loop bit disagrees with the mode");
  AST_STOPPED: assert property (loop_tick && assl_abs(actual_speed) < assl_pkg::STOP_BELOW
    |=> status_bits[1]) // [RQ17]
    else $error("stopped bit not set at low speed");
  AST_INPOS_CL: assert property (status_bits[0] |-> !status_bits[3] && status_bits[5:4] == 2'h0) // [RQ18]
    else $error("in position outside a closed-loop stop");
  AST_FREEZE: assert property (loop_tick ##1 (status_bits[2] && status_bits[5:4] == 2'h0)
    |-> integ_freeze) // [RQ16]
    else $error("integrator not frozen while halted");

endmodule : assl_axis_status

/* assl_loop_model.sv */
// control loop partner: paces the status refresh ticks
`timescale 1ns/1ps
module assl_loop_model #(
  parameter int unsigned PERIOD = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // update pulse
  output logic loop_tick
);
  logic [7:0] cnt_reg; // cycles since last update
  // one update pulse every PERIOD cycles, idle in reset
  always_ff @(posedge clk) begin
    if (reset || cnt_reg == 8'(PERIOD - 1)) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
    loop_tick <= !reset && cnt_reg == 8'(PERIOD - 1);
  end
endmodule : assl_loop_model

/* axis_status_low_bits_test.sv */
// testbench: status bits driven through commands and loop samples
`timescale 1ns/1ps
module axis_status_low_bits_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic stb = 1'b0;
  logic cyc = 1'b0;
  logic ack;
  logic tick;
  logic [31:0] spd = 32'h0;
  logic [31:0] apos = 32'h0;
  logic [4:0] tgv = 5'h00; // busy, rising, falling, request, upper half
  logic hstop = 1'b0;
  logic [5:0] status_bits;
  logic [15:0] drive_mv;
  logic freeze;
  logic sstop = 1'b0; // soft stop event
  logic xdcr = 1'b0; // soft stop is a transducer fault
  logic tstart; // generator start pulse
  logic [8:0] mv; // move type shown to the generator
  logic q_start; // start pulse seen at the ack edge
  logic [31:0] q;
  int n_errors = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  assl_loop_model #(.PERIOD(4)) loop_m (.clk(clk), .reset(reset), .loop_tick(tick));
  assl_axis_status #(.MS_CYCLES(20)) DUT (
    .clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .loop_tick(tick),
    .actual_speed(spd), .actual_pos(apos), .command_pos(32'h0), .tg_busy(tgv[4]),
    .tg_rising(tgv[3]), .tg_falling(tgv[2]), .tg_req_nonzero(tgv[1]), .tg_upper_half(tgv[0]),
    .hard_stop(hstop), .soft_stop(sstop), .soft_stop_xdcr(xdcr), .status_bits(status_bits),
    .drive_mv(drive_mv), .integ_freeze(freeze), .tg_start(tstart), .tg_move(mv)
  );
  ////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = rdat;
    q_start = tstart;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // command write
  task cmd(input logic [31:0] c);
    wb(1'b1, assl_pkg::ADR_COMMAND, c);
  endtask : cmd
  // let several loop updates pass, then check status
  task st(input logic [5:0] e);
    repeat (12) @(posedge clk);
    chk({26'h0, status_bits}, {26'h0, e});
  endtask : st
  // set generator progress then check status
  task ts(input logic [4:0] v, input logic [5:0] e);
    @(posedge clk);
    tgv <= v;
    st(e);
  endtask : ts
  // one-cycle stop event: hard, soft, transducer fault
  task stop_pulse(input logic h, input logic s, input logic x);
    @(posedge clk);
    hstop <= h;
    sstop <= s;
    xdcr <= x;
    @(posedge clk);
    hstop <= 1'b0;
    sstop <= 1'b0;
    xdcr <= 1'b0;
  endtask : stop_pulse
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    st(6'h0A);
    wb(1'b0, assl_pkg::ADR_STATUS, 32'h0);
    chk(q, 32'h0000_000A);
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, assl_pkg::ADR_NULL_DRIVE, 32'h20);
    wb(1'b1, assl_pkg::ADR_ACCEL, 32'h20);
    wb(1'b1, assl_pkg::ADR_DECEL, 32'h20);
    cmd(32'h01);
    st(6'h03);
    apos <= 32'h10;
    st(6'h02);
    apos <= 32'h0F;
    st(6'h03);
    spd <= 32'd100;
    st(6'h03);
    spd <= 32'd200;
    st(6'h01);
    spd <= 32'd100;
    st(6'h01);
    spd <= 32'd10;
    st(6'h03);
    cmd(32'h103);
    chk({22'h0, q_start, mv}, {22'h0, 1'b1, assl_pkg::MV_GEAR});
    ts(5'b11010, 6'h12);
    ts(5'b00010, 6'h22);
    ts(5'b10100, 6'h32);
    ts(5'b00000, 6'h02);
    cmd(32'h203);
    chk({22'h0, q_start, mv}, {22'h0, 1'b1, assl_pkg::MV_SPEED});
    ts(5'b11010, 6'h12);
    ts(5'b00010, 6'h22);
    ts(5'b10100, 6'h32);
    ts(5'b00000, 6'h03);
    cmd(32'h06);
    ts(5'b11000, 6'h12);
    ts(5'b10100, 6'h32);
    ts(5'b00000, 6'h03);
    cmd(32'h30);
    ts(5'b10000, 6'h12);
    ts(5'b10001, 6'h32);
    ts(5'b00000, 6'h03);
    cmd(32'h05);
    chk({23'h0, mv}, {23'h0, assl_pkg::MV_SPLINE});
    ts(5'b11010, 6'h02);
    cmd(32'h09);
    chk({22'h0, q_start, mv}, {22'h0, 1'b1, assl_pkg::MV_HALT});
    ts(5'b10100, 6'h36);
    ts(5'b00000, 6'h07);
    chk({31'h0, freeze}, 32'h1);
    cmd(32'h01);
    st(6'h03);
    chk({31'h0, freeze}, 32'h0);
    stop_pulse(1'b1, 1'b0, 1'b0);
    st(6'h0E);
    chk({23'h0, mv}, {23'h0, assl_pkg::MV_OPEN});
    chk({16'h0, drive_mv}, 32'h20);
    wb(1'b1, assl_pkg::ADR_CMD_VALUE, 32'h40);
    cmd(32'h07);
    st(6'h1E);
    repeat (100) @(posedge clk);
    st(6'h2E);
    chk({16'h0, drive_mv}, 32'h60);
    wb(1'b1, assl_pkg::ADR_CMD_VALUE, 32'h0);
    cmd(32'h07);
    st(6'h3E);
    repeat (100) @(posedge clk);
    st(6'h0E);
    wb(1'b0, assl_pkg::ADR_DRIVE, 32'h0);
    chk(q, 32'h20);
    cmd(32'h01);
    st(6'h03);
    stop_pulse(1'b0, 1'b1, 1'b0);
    st(6'h07);
    chk({23'h0, mv}, {23'h0, assl_pkg::MV_HALT});
    wb(1'b1, assl_pkg::ADR_CMD_VALUE, 32'hE0);
    cmd(32'h07);
    chk({31'h0, q_start}, 32'h0);
    repeat (200) @(posedge clk);
    st(6'h2E);
    chk({16'h0, drive_mv}, 32'h100);
    stop_pulse(1'b0, 1'b1, 1'b1);
    st(6'h3E);
    chk({23'h0, mv}, {23'h0, assl_pkg::MV_OPEN});
    repeat (50) @(posedge clk);
    st(6'h0E);
    chk({16'h0, drive_mv}, 32'h20);
    give_verdict;
  end
endmodule : axis_status_low_bits_test
